// *** logic/port_alt_function_override.v ***
`timescale 1ns/1ns
`default_nettype none
`include "port_override_regs.vh"
// Operation
// - Pull-up follows override value when enabled, else on for code 010.
// - Driver follows direction override when enabled, else direction bit.
// - Enabled driver outputs override value instead of latch when enabled.
// - Input buffer follows override when enabled, else sleep controller decides.
// - First port: upper pins segments 3..0, lower pins commons 3..0.
// - Segment pins: panel enable overrides pull-up, direction, input with zero.
// - Commons 3..1 gated by panel enable and duty term; common 0 by enable.
// - Second-port pins 7..4 carry timer compare and PWM outputs.
// - Compare pins: value override from compare enable and output.
// - Second-port pin n feeds pin-change n+8; input forced on when armed.
// - SPI master forces MISO input; slave leaves direction bit in charge.
// - SPI slave forces MOSI, SCK, SS inputs; master leaves direction bits.
// - Forced-input SPI pin pull-up follows latch gated by global pull-up off.
// - Slave SPI active only while select pin is low.
// - SPI overrides from enable and role; data and clock value overrides.
// - Pin inputs routed to SPI receive, clock and select inputs.
// - Third port: all eight pins are segment drives.
module port_alt_function_override #(
  parameter WIDTH = `PORT_WIDTH
) (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Common controls
  input wire global_pullup_off_i,
  input wire sleep_i,
  // Port registers and pad inputs
  input wire [WIDTH-1:0] first_dir_i,
  input wire [WIDTH-1:0] first_latch_i,
  input wire [WIDTH-1:0] second_dir_i,
  input wire [WIDTH-1:0] second_latch_i,
  input wire [WIDTH-1:0] second_pad_i,
  input wire [WIDTH-1:0] third_dir_i,
  input wire [WIDTH-1:0] third_latch_i,
  // Panel driver
  input wire panel_driver_on_i,
  input wire [2:0] panel_duty_select_term_i,
  input wire [3:0] front_plane_drive_i,
  input wire [3:0] back_plane_drive_i,
  input wire [WIDTH-1:0] third_front_plane_drive_i,
  // Timers
  input wire [3:0] match_out_en_i,
  input wire timer2_match_a_out_i,
  input wire timer1_match_b_out_i,
  input wire timer1_match_a_out_i,
  input wire timer0_match_a_out_i,
  // Pin change
  input wire pin_change_group1_on_i,
  input wire [WIDTH-1:0] pin_change_mask_i,
  // Serial port
  input wire serial_port_on_i,
  input wire serial_controller_role_i,
  input wire spi_slave_data_out_i,
  input wire spi_master_data_out_i,
  input wire spi_clock_out_i,
  // Pad controls, per port
  output wire [WIDTH-1:0] first_pullup_o,
  output wire [WIDTH-1:0] first_drive_en_o,
  output wire [WIDTH-1:0] first_drive_val_o,
  output wire [WIDTH-1:0] first_input_en_o,
  output wire [WIDTH-1:0] first_panel_link_o,
  output wire [WIDTH-1:0] second_pullup_o,
  output wire [WIDTH-1:0] second_drive_en_o,
  output wire [WIDTH-1:0] second_drive_val_o,
  output wire [WIDTH-1:0] second_input_en_o,
  output wire [WIDTH-1:0] third_pullup_o,
  output wire [WIDTH-1:0] third_drive_en_o,
  output wire [WIDTH-1:0] third_drive_val_o,
  output wire [WIDTH-1:0] third_input_en_o,
  output wire [WIDTH-1:0] third_panel_link_o,
  // Functional inputs
  output wire [15:0] pin_change_src_o,
  output wire spi_master_rx_o,
  output wire spi_slave_rx_o,
  output wire spi_clock_in_o,
  output wire spi_select_n_o,
  output wire spi_slave_active_o
);
  // First-port override enables
  wire [WIDTH-1:0] f_pullup_override_en;
  wire [WIDTH-1:0] f_doe;
  wire [WIDTH-1:0] f_ieoe;
  // Second-port override enables and values
  wire [WIDTH-1:0] s_pullup_override_en;
  wire [WIDTH-1:0] s_pullup_override_val;
  wire [WIDTH-1:0] s_doe;
  wire [WIDTH-1:0] s_pin_value_override_en;
  wire [WIDTH-1:0] s_pin_value_override_val;
  wire [WIDTH-1:0] s_ieoe;
  // Third-port override enable
  wire [WIDTH-1:0] t_ovr;
  // Resolved pad controls per port
  wire [WIDTH-1:0] f_pu;
  wire [WIDTH-1:0] f_de;
  wire [WIDTH-1:0] f_dv;
  wire [WIDTH-1:0] f_ie;
  wire [WIDTH-1:0] s_pu;
  wire [WIDTH-1:0] s_de;
  wire [WIDTH-1:0] s_dv;
  wire [WIDTH-1:0] s_ie;
  wire [WIDTH-1:0] t_pu;
  wire [WIDTH-1:0] t_de;
  wire [WIDTH-1:0] t_dv;
  wire [WIDTH-1:0] t_ie;
  wire [3:0] timer_val;
  wire spi_serial_controller_role;
  wire spi_slv;
  // Pad-side registers behind every output
  reg [WIDTH-1:0] first_pullup_ff;
  reg [WIDTH-1:0] first_drive_en_ff;
  reg [WIDTH-1:0] first_drive_val_ff;
  reg [WIDTH-1:0] first_input_en_ff;
  reg [WIDTH-1:0] first_panel_link_ff;
  reg [WIDTH-1:0] second_pullup_ff;
  reg [WIDTH-1:0] second_drive_en_ff;
  reg [WIDTH-1:0] second_drive_val_ff;
  reg [WIDTH-1:0] second_input_en_ff;
  reg [WIDTH-1:0] third_pullup_ff;
  reg [WIDTH-1:0] third_drive_en_ff;
  reg [WIDTH-1:0] third_drive_val_ff;
  reg [WIDTH-1:0] third_input_en_ff;
  reg [WIDTH-1:0] third_panel_link_ff;
  reg [15:0] pin_change_src_ff;
  reg spi_master_rx_ff;
  reg spi_slave_rx_ff;
  reg spi_clock_in_ff;
  reg spi_select_n_ff;
  reg spi_slave_active_ff;

  // Segment pins gated by enable only; commons 3..1 also by duty term
  assign f_pullup_override_en[7:4] = {4{panel_driver_on_i}};
  assign f_pullup_override_en[3:1] = {3{panel_driver_on_i}} & panel_duty_select_term_i;
  assign f_pullup_override_en[0] = panel_driver_on_i;
  assign f_doe = f_pullup_override_en;
  assign f_ieoe = f_pullup_override_en;
  // Third port has no other function, so panel enable alone takes it
  assign t_ovr = {WIDTH{panel_driver_on_i}};

  // Serial port off leaves every SPI pin to its port registers
  assign spi_serial_controller_role = serial_port_on_i & serial_controller_role_i;
  assign spi_slv = serial_port_on_i & ~serial_controller_role_i;
  assign timer_val = {timer2_match_a_out_i, timer1_match_b_out_i,
    timer1_match_a_out_i, timer0_match_a_out_i};

  // Compare pins never touch pull-up or direction; software owns direction
  assign s_pullup_override_en[7:4] = 4'h0;
  assign s_pullup_override_val[7:4] = 4'h0;
  assign s_doe[7:4] = 4'h0;
  assign s_pin_value_override_en[7:4] = match_out_en_i;
  assign s_pin_value_override_val[7:4] = timer_val;
  // MISO forced input as master, others as slave
  assign s_doe[`SPI_MISO_BIT] = spi_serial_controller_role;
  assign s_doe[`SPI_MOSI_BIT] = spi_slv;
  assign s_doe[`SPI_SCK_BIT] = spi_slv;
  assign s_doe[`SPI_SS_BIT] = spi_slv;
  assign s_pullup_override_en[3:0] = s_doe[3:0];
  // Pull-up kept as latch bit with global disable honoured
  assign s_pullup_override_val[3:0] = second_latch_i[3:0] & {4{~global_pullup_off_i}};
  assign s_pin_value_override_en[`SPI_MISO_BIT] = spi_slv;
  assign s_pin_value_override_en[`SPI_MOSI_BIT] = spi_serial_controller_role;
  assign s_pin_value_override_en[`SPI_SCK_BIT] = spi_serial_controller_role;
  assign s_pin_value_override_en[`SPI_SS_BIT] = 1'b0;
  assign s_pin_value_override_val[3:0] = {spi_slave_data_out_i, spi_master_data_out_i, spi_clock_out_i, 1'b0};
  // Armed pin-change pins keep their input buffer awake through sleep
  assign s_ieoe = pin_change_mask_i & {WIDTH{pin_change_group1_on_i}};

  // One cell per pin and port; the ports differ only in override wiring
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
      pin_override_cell u_first (
        .dir_bit_i(first_dir_i[i]),
        .latch_bit_i(first_latch_i[i]),
        .global_pullup_off_i(global_pullup_off_i),
        .sleep_i(sleep_i),
        .pullup_override_en_i(f_pullup_override_en[i]),
        .pullup_override_val_i(1'b0),
        .direction_override_en_i(f_doe[i]),
        .direction_override_val_i(1'b0),
        .pin_value_override_en_i(1'b0),
        .pin_value_override_val_i(1'b0),
        .input_buffer_override_en_i(f_ieoe[i]),
        .input_buffer_override_val_i(1'b0),
        .pullup_o(f_pu[i]),
        .drive_en_o(f_de[i]),
        .drive_val_o(f_dv[i]),
        .input_en_o(f_ie[i])
      );
      pin_override_cell u_second (
        .dir_bit_i(second_dir_i[i]),
        .latch_bit_i(second_latch_i[i]),
        .global_pullup_off_i(global_pullup_off_i),
        .sleep_i(sleep_i),
        .pullup_override_en_i(s_pullup_override_en[i]),
        .pullup_override_val_i(s_pullup_override_val[i]),
        .direction_override_en_i(s_doe[i]),
        .direction_override_val_i(1'b0),
        .pin_value_override_en_i(s_pin_value_override_en[i]),
        .pin_value_override_val_i(s_pin_value_override_val[i]),
        .input_buffer_override_en_i(s_ieoe[i]),
        .input_buffer_override_val_i(1'b1),
        .pullup_o(s_pu[i]),
        .drive_en_o(s_de[i]),
        .drive_val_o(s_dv[i]),
        .input_en_o(s_ie[i])
      );
      pin_override_cell u_third (
        .dir_bit_i(third_dir_i[i]),
        .latch_bit_i(third_latch_i[i]),
        .global_pullup_off_i(global_pullup_off_i),
        .sleep_i(sleep_i),
        .pullup_override_en_i(t_ovr[i]),
        .pullup_override_val_i(1'b0),
        .direction_override_en_i(t_ovr[i]),
        .direction_override_val_i(1'b0),
        .pin_value_override_en_i(1'b0),
        .pin_value_override_val_i(1'b0),
        .input_buffer_override_en_i(t_ovr[i]),
        .input_buffer_override_val_i(1'b0),
        .pullup_o(t_pu[i]),
        .drive_en_o(t_de[i]),
        .drive_val_o(t_dv[i]),
        .input_en_o(t_ie[i])
      );
    end
  endgenerate

  // Flopped at the pad boundary so every output is a register
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      first_pullup_ff <= `OUT_RESET;
      first_drive_en_ff <= `OUT_RESET;
      first_drive_val_ff <= `OUT_RESET;
      first_input_en_ff <= `OUT_RESET;
      first_panel_link_ff <= `OUT_RESET;
      second_pullup_ff <= `OUT_RESET;
      second_drive_en_ff <= `OUT_RESET;
      second_drive_val_ff <= `OUT_RESET;
      second_input_en_ff <= `OUT_RESET;
      third_pullup_ff <= `OUT_RESET;
      third_drive_en_ff <= `OUT_RESET;
      third_drive_val_ff <= `OUT_RESET;
      third_input_en_ff <= `OUT_RESET;
      third_panel_link_ff <= `OUT_RESET;
      pin_change_src_ff <= `SRC_RESET;
      spi_master_rx_ff <= `BIT_RESET;
      spi_slave_rx_ff <= `BIT_RESET;
      spi_clock_in_ff <= `BIT_RESET;
      // Select idles high so reset never looks like a selected slave
      spi_select_n_ff <= `SELECT_N_RESET;
      spi_slave_active_ff <= `BIT_RESET;
    end else begin
      first_pullup_ff <= f_pu;
      first_drive_en_ff <= f_de;
      first_drive_val_ff <= f_dv;
      first_input_en_ff <= f_ie;
      first_panel_link_ff <= {front_plane_drive_i, back_plane_drive_i};
      second_pullup_ff <= s_pu;
      second_drive_en_ff <= s_de;
      second_drive_val_ff <= s_dv;
      second_input_en_ff <= s_ie;
      third_pullup_ff <= t_pu;
      third_drive_en_ff <= t_de;
      third_drive_val_ff <= t_dv;
      third_input_en_ff <= t_ie;
      third_panel_link_ff <= third_front_plane_drive_i;
      pin_change_src_ff <= {second_pad_i, 8'h00};
      spi_master_rx_ff <= second_pad_i[`SPI_MISO_BIT];
      spi_slave_rx_ff <= second_pad_i[`SPI_MOSI_BIT];
      spi_clock_in_ff <= second_pad_i[`SPI_SCK_BIT];
      spi_select_n_ff <= second_pad_i[`SPI_SS_BIT];
      spi_slave_active_ff <= spi_slv & ~second_pad_i[`SPI_SS_BIT];
    end
  end

  // Ports come straight from the pad-side registers
  assign first_pullup_o = first_pullup_ff;
  assign first_drive_en_o = first_drive_en_ff;
  assign first_drive_val_o = first_drive_val_ff;
  assign first_input_en_o = first_input_en_ff;
  assign first_panel_link_o = first_panel_link_ff;
  assign second_pullup_o = second_pullup_ff;
  assign second_drive_en_o = second_drive_en_ff;
  assign second_drive_val_o = second_drive_val_ff;
  assign second_input_en_o = second_input_en_ff;
  assign third_pullup_o = third_pullup_ff;
  assign third_drive_en_o = third_drive_en_ff;
  assign third_drive_val_o = third_drive_val_ff;
  assign third_input_en_o = third_input_en_ff;
  assign third_panel_link_o = third_panel_link_ff;
  assign pin_change_src_o = pin_change_src_ff;
  assign spi_master_rx_o = spi_master_rx_ff;
  assign spi_slave_rx_o = spi_slave_rx_ff;
  assign spi_clock_in_o = spi_clock_in_ff;
  assign spi_select_n_o = spi_select_n_ff;
  assign spi_slave_active_o = spi_slave_active_ff;
endmodule // port_alt_function_override
`default_nettype wire

// *** logic/port_override_regs.vh ***
`ifndef PORT_OVERRIDE_REGS_VH
`define PORT_OVERRIDE_REGS_VH
// Port width in pins
`define PORT_WIDTH 8
// Second-port pin feeds pin-change source base plus pin index
`define PIN_CHANGE_BASE 8
// Pull-up enable code {dir, latch, global_pullup_off}
`define PULLUP_ON_CODE 3'b010
// Second-port pin positions
`define SPI_SS_BIT 0
`define SPI_SCK_BIT 1
`define SPI_MOSI_BIT 2
`define SPI_MISO_BIT 3
`define TIMER0_A_BIT 4
`define TIMER1_A_BIT 5
`define TIMER1_B_BIT 6
`define TIMER2_A_BIT 7
// Reset values of the flopped outputs
`define OUT_RESET 8'h00
`define SRC_RESET 16'h0000
`define BIT_RESET 1'b0
// Slave select idles high
`define SELECT_N_RESET 1'b1
`endif

// *** logic/pin_override_cell.v ***
`timescale 1ns/1ns
`default_nettype none
`include "port_override_regs.vh"
// Generic per-pin override resolution shared by all three ports
module pin_override_cell (
  // Register side
  input wire dir_bit_i,
  input wire latch_bit_i,
  input wire global_pullup_off_i,
  input wire sleep_i,
  // Override signals
  input wire pullup_override_en_i,
  input wire pullup_override_val_i,
  input wire direction_override_en_i,
  input wire direction_override_val_i,
  input wire pin_value_override_en_i,
  input wire pin_value_override_val_i,
  input wire input_buffer_override_en_i,
  input wire input_buffer_override_val_i,
  // Pad controls
  output wire pullup_o,
  output wire drive_en_o,
  output wire drive_val_o,
  output wire input_en_o
);
  assign pullup_o = pullup_override_en_i ? pullup_override_val_i :
    ({dir_bit_i, latch_bit_i, global_pullup_off_i} == `PULLUP_ON_CODE);
  assign drive_en_o = direction_override_en_i ? direction_override_val_i : dir_bit_i;
  assign drive_val_o = pin_value_override_en_i ? pin_value_override_val_i : latch_bit_i;
  assign input_en_o = input_buffer_override_en_i ? input_buffer_override_val_i : ~sleep_i;
endmodule // pin_override_cell
`default_nettype wire

// *** test/port_override_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module port_override_chk #(
  parameter WIDTH = 8
) (
  // Clock, reset and watched inputs
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic global_pullup_off_i,
  input wire logic panel_driver_on_i,
  input wire logic pin_change_group1_on_i,
  input wire logic serial_port_on_i,
  input wire logic serial_controller_role_i,
  input wire logic timer2_match_a_out_i,
  input wire logic [2:0] panel_duty_select_term_i,
  input wire logic [3:0] match_out_en_i,
  input wire logic [WIDTH-1:0] first_dir_i,
  input wire logic [WIDTH-1:0] second_pad_i,
  input wire logic [WIDTH-1:0] second_latch_i,
  input wire logic [WIDTH-1:0] pin_change_mask_i,
  // Watched outputs
  input wire logic [WIDTH-1:0] first_pullup_o,
  input wire logic [WIDTH-1:0] first_drive_en_o,
  input wire logic [WIDTH-1:0] first_input_en_o,
  input wire logic [WIDTH-1:0] second_pullup_o,
  input wire logic [WIDTH-1:0] second_drive_en_o,
  input wire logic [WIDTH-1:0] second_drive_val_o,
  input wire logic [WIDTH-1:0] second_input_en_o,
  input wire logic [WIDTH-1:0] third_drive_en_o,
  input wire logic [WIDTH-1:0] third_input_en_o,
  input wire logic [15:0] pin_change_src_o,
  input wire logic spi_slave_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  seg_off_a: assert property (
    panel_driver_on_i |=> !first_drive_en_o[0] &&
    (first_drive_en_o[7:4] | first_input_en_o[7:4] | first_pullup_o[7:4]) == 4'h0)
    else $error("panel pins kept");
  com_gate_a: assert property (
    panel_driver_on_i && !panel_duty_select_term_i[0] && first_dir_i[1] |=> first_drive_en_o[1])
    else $error("common pin gated wrongly");
  match_val_a: assert property (
    match_out_en_i[3] |=> second_drive_val_o[7] == $past(timer2_match_a_out_i))
    else $error("compare value lost");
  pc_src_a: assert property (
    !sys_rst_i |=> pin_change_src_o == {$past(second_pad_i), 8'h00})
    else $error("pin change source wrong");
  pc_in_a: assert property (
    pin_change_group1_on_i && pin_change_mask_i[5] |=> second_input_en_o[5])
    else $error("armed input not forced");
  miso_in_a: assert property (
    serial_port_on_i && serial_controller_role_i |=> !second_drive_en_o[3])
    else $error("master input driven");
  slave_in_a: assert property (
    serial_port_on_i && !serial_controller_role_i |=> second_drive_en_o[2:0] == 3'h0)
    else $error("slave inputs driven");
  spi_pull_a: assert property (
    serial_port_on_i && serial_controller_role_i |=>
    second_pullup_o[3] == ($past(second_latch_i[3]) && !$past(global_pullup_off_i)))
    else $error("forced input pull-up wrong");
  slave_act_a: assert property (
    serial_port_on_i && !serial_controller_role_i && !second_pad_i[0] |=> spi_slave_active_o)
    else $error("selected slave idle");
  third_seg_a: assert property (
    panel_driver_on_i |=> (third_drive_en_o | third_input_en_o) == 8'h00)
    else $error("third port not released");
endmodule // port_override_chk
`default_nettype wire

// *** test/pad_far_side.sv ***
`timescale 1ns/1ns
`default_nettype none
module pad_far_side (
  // Pad controls from the block
  input wire logic clk_i,
  input wire logic [7:0] drive_en_i,
  input wire logic [7:0] drive_val_i,
  input wire logic [7:0] pullup_i,
  // Outside parties on the pins
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output var logic [7:0] pad_o
);
  integer i;
  initial pad_o = 8'h00;
  // Undriven unpulled pin wanders so a stale level never passes
  always @(posedge clk_i) begin
    for (i = 0; i < 8; i = i + 1) begin
      if (drive_en_i[i]) pad_o[i] <= drive_val_i[i];
      else if (ext_en_i[i]) pad_o[i] <= ext_val_i[i];
      else if (pullup_i[i]) pad_o[i] <= 1'b1;
      else pad_o[i] <= ~pad_o[i];
    end
  end
endmodule // pad_far_side
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_i, sys_rst_i, global_pullup_off_i, sleep_i, panel_driver_on_i;
  logic timer2_match_a_out_i, timer1_match_b_out_i, timer1_match_a_out_i, timer0_match_a_out_i;
  logic serial_port_on_i, serial_controller_role_i, spi_slave_data_out_i, spi_master_data_out_i;
  logic spi_clock_out_i, pin_change_group1_on_i;
  logic [2:0] panel_duty_select_term_i;
  logic [3:0] front_plane_drive_i, back_plane_drive_i, match_out_en_i;
  logic [7:0] first_dir_i, first_latch_i, second_dir_i, second_latch_i, second_pad_i, ext_en;
  logic [7:0] third_dir_i, third_latch_i, third_front_plane_drive_i, pin_change_mask_i, ext_val;
  logic [7:0] first_pullup_o, first_drive_en_o, first_drive_val_o, first_input_en_o;
  logic [7:0] first_panel_link_o, second_pullup_o, second_drive_en_o, second_drive_val_o;
  logic [7:0] second_input_en_o, third_pullup_o, third_drive_en_o, third_drive_val_o;
  logic [7:0] third_input_en_o, third_panel_link_o;
  logic [15:0] pin_change_src_o;
  logic spi_master_rx_o, spi_slave_rx_o, spi_clock_in_o, spi_select_n_o, spi_slave_active_o;
  int n_mismatch, compares, i;
  port_alt_function_override dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .global_pullup_off_i(global_pullup_off_i),
    .sleep_i(sleep_i), .first_dir_i(first_dir_i), .first_latch_i(first_latch_i),
    .second_dir_i(second_dir_i), .second_latch_i(second_latch_i), .second_pad_i(second_pad_i),
    .third_dir_i(third_dir_i), .third_latch_i(third_latch_i),
    .panel_driver_on_i(panel_driver_on_i), .panel_duty_select_term_i(panel_duty_select_term_i),
    .front_plane_drive_i(front_plane_drive_i), .back_plane_drive_i(back_plane_drive_i),
    .third_front_plane_drive_i(third_front_plane_drive_i), .match_out_en_i(match_out_en_i),
    .timer2_match_a_out_i(timer2_match_a_out_i), .timer1_match_b_out_i(timer1_match_b_out_i),
    .timer1_match_a_out_i(timer1_match_a_out_i), .timer0_match_a_out_i(timer0_match_a_out_i),
    .pin_change_group1_on_i(pin_change_group1_on_i), .pin_change_mask_i(pin_change_mask_i),
    .serial_port_on_i(serial_port_on_i), .serial_controller_role_i(serial_controller_role_i),
    .spi_slave_data_out_i(spi_slave_data_out_i), .spi_master_data_out_i(spi_master_data_out_i),
    .spi_clock_out_i(spi_clock_out_i),
    .first_pullup_o(first_pullup_o), .first_drive_en_o(first_drive_en_o),
    .first_drive_val_o(first_drive_val_o), .first_input_en_o(first_input_en_o),
    .first_panel_link_o(first_panel_link_o), .second_pullup_o(second_pullup_o),
    .second_drive_en_o(second_drive_en_o), .second_drive_val_o(second_drive_val_o),
    .second_input_en_o(second_input_en_o), .third_pullup_o(third_pullup_o),
    .third_drive_en_o(third_drive_en_o), .third_drive_val_o(third_drive_val_o),
    .third_input_en_o(third_input_en_o), .third_panel_link_o(third_panel_link_o),
    .pin_change_src_o(pin_change_src_o), .spi_master_rx_o(spi_master_rx_o),
    .spi_slave_rx_o(spi_slave_rx_o), .spi_clock_in_o(spi_clock_in_o),
    .spi_select_n_o(spi_select_n_o), .spi_slave_active_o(spi_slave_active_o));
  pad_far_side far (.clk_i(clk_i), .drive_en_i(second_drive_en_o),
    .drive_val_i(second_drive_val_o), .pullup_i(second_pullup_o), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_o(second_pad_i));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Whole run is some thirty cycles
  initial begin
    #5000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {global_pullup_off_i, sleep_i, panel_driver_on_i, timer2_match_a_out_i} = '0;
    {timer1_match_b_out_i, timer1_match_a_out_i, timer0_match_a_out_i, serial_port_on_i} = '0;
    {serial_controller_role_i, spi_slave_data_out_i, spi_master_data_out_i} = '0;
    {spi_clock_out_i, pin_change_group1_on_i, panel_duty_select_term_i, match_out_en_i} = '0;
    {front_plane_drive_i, back_plane_drive_i, first_dir_i, first_latch_i, ext_en} = '0;
    {second_dir_i, second_latch_i, third_dir_i, third_latch_i, ext_val} = '0;
    {third_front_plane_drive_i, pin_change_mask_i} = '0;
    sys_rst_i = 1'b1;
    settle(1);
    chk("reset select_n", 16'h1, spi_select_n_o);
    chk("reset drive_en", 16'h0, first_drive_en_o);
    @(posedge clk_i);
    sys_rst_i <= 1'b0;
    panel_driver_on_i <= 1'b1;
    panel_duty_select_term_i <= 3'h2;
    first_dir_i <= 8'hff;
    first_latch_i <= 8'hff;
    third_dir_i <= 8'hff;
    front_plane_drive_i <= 4'h9;
    back_plane_drive_i <= 4'h6;
    third_front_plane_drive_i <= 8'h5a;
    third_latch_i <= 8'h3c;
    settle(1);
    chk("first drive_en", 16'h0a, first_drive_en_o);
    chk("first input_en", 16'h0a, first_input_en_o);
    chk("first panel", 16'h96, first_panel_link_o);
    chk("third drive_en", 16'h00, third_drive_en_o);
    chk("third panel", 16'h5a, third_panel_link_o);
    chk("third pull input", 16'h00, {third_pullup_o, third_input_en_o});
    chk("third drive_val", 16'h3c, third_drive_val_o);
    @(posedge clk_i);
    panel_driver_on_i <= 1'b0;
    first_dir_i <= 8'h0f;
    first_latch_i <= 8'h3c;
    sleep_i <= 1'b1;
    settle(1);
    chk("first pullup", 16'h30, first_pullup_o);
    chk("first drive_en", 16'h0f, first_drive_en_o);
    chk("first drive_val", 16'h3c, first_drive_val_o);
    chk("first input_en", 16'h00, first_input_en_o);
    chk("third drive_en off", 16'hff, third_drive_en_o);
    @(posedge clk_i);
    global_pullup_off_i <= 1'b1;
    second_dir_i <= 8'hf0;
    match_out_en_i <= 4'hf;
    settle(1);
    chk("pullup off", 16'h00, first_pullup_o);
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {timer2_match_a_out_i, timer1_match_b_out_i, timer1_match_a_out_i,
        timer0_match_a_out_i} <= 4'h1 << i;
      settle(1);
      chk("compare pins", 16'hf0 | (16'h1 << i),
        {second_drive_en_o[7:4], second_drive_val_o[7:4]});
    end
    @(posedge clk_i);
    match_out_en_i <= 4'h0;
    second_latch_i <= 8'ha0;
    pin_change_group1_on_i <= 1'b1;
    pin_change_mask_i <= 8'h21;
    settle(1);
    chk("latch pins", 16'ha0, second_drive_val_o[7:4] << 4);
    chk("second input_en", 16'h21, second_input_en_o);
    @(posedge clk_i);
    global_pullup_off_i <= 1'b0;
    serial_port_on_i <= 1'b1;
    serial_controller_role_i <= 1'b1;
    second_dir_i <= 8'h0f;
    second_latch_i <= 8'h08;
    spi_master_data_out_i <= 1'b1;
    spi_clock_out_i <= 1'b1;
    ext_en <= 8'h08;
    settle(3);
    chk("master pins", 16'h3c6, {second_drive_en_o[3:0], second_pullup_o[3:0],
      second_drive_val_o[2:0]});
    chk("master rx", 16'h0, {spi_master_rx_o, pin_change_src_o[11]});
    @(posedge clk_i);
    serial_controller_role_i <= 1'b0;
    second_latch_i <= 8'h00;
    spi_slave_data_out_i <= 1'b1;
    ext_en <= 8'h07;
    ext_val <= 8'h06;
    settle(3);
    chk("slave pins", 16'h88, {second_drive_en_o[3:0], second_drive_val_o[3:0]});
    chk("slave in", 16'he, {spi_slave_active_o, spi_slave_rx_o, spi_clock_in_o,
      spi_select_n_o});
    @(posedge clk_i);
    ext_val <= 8'h07;
    settle(3);
    chk("deselect", 16'h1, {spi_slave_active_o, spi_select_n_o});
    print_verdict();
  end
endmodule // tb
bind port_alt_function_override port_override_chk #(.WIDTH(WIDTH)) chk_u (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .global_pullup_off_i(global_pullup_off_i),
  .panel_driver_on_i(panel_driver_on_i), .pin_change_group1_on_i(pin_change_group1_on_i),
  .serial_port_on_i(serial_port_on_i), .serial_controller_role_i(serial_controller_role_i),
  .timer2_match_a_out_i(timer2_match_a_out_i),
  .panel_duty_select_term_i(panel_duty_select_term_i),
  .match_out_en_i(match_out_en_i), .first_dir_i(first_dir_i), .second_pad_i(second_pad_i),
  .second_latch_i(second_latch_i), .pin_change_mask_i(pin_change_mask_i),
  .first_pullup_o(first_pullup_o), .first_drive_en_o(first_drive_en_o),
  .first_input_en_o(first_input_en_o), .second_pullup_o(second_pullup_o),
  .second_drive_en_o(second_drive_en_o), .second_drive_val_o(second_drive_val_o),
  .second_input_en_o(second_input_en_o), .third_drive_en_o(third_drive_en_o),
  .third_input_en_o(third_input_en_o), .pin_change_src_o(pin_change_src_o),
  .spi_slave_active_o(spi_slave_active_o));
`default_nettype wire
